// ==== amd_pkg.sv ====
// constants, types and encodings for the addressing-mode decoder
// Summary of operation
// RULE1 - Immediate instruction is exactly opcode plus one operand value byte.
// RULE2 - Short direct takes one address byte, reaching 00 to FF.
// RULE3 - Long direct takes a two-byte address word, reaching full 64 Kbyte.
// RULE4 - Indexed address is unsigned sum of selected index register and offset.
// RULE5 - No-offset indexed has no extra byte; index alone is address 00-FF.
// RULE6 - Short indexed takes one offset byte; sum reaches 00 to 1FE.
// RULE7 - Long indexed takes an offset word; sum reaches full 64 Kbyte.
// RULE8 - Short indirect reads one pointer byte from page-zero location given.
// RULE9 - Long indirect reads a pointer word from page-zero location given.
// RULE10 - Indirect indexed address is index plus pointer fetched from memory.
// RULE11 - Short indirect indexed uses byte pointer (00-1FE); long uses word.
// RULE12 - Load, compare, bit compare, logic, arithmetic accept short and long.
// RULE13 - Read-modify-write, bit, shift, swap, call and jump accept short only.
// RULE14 - Relative mode adds a signed 8-bit offset to the program counter.
// RULE15 - Relative direct offset follows opcode; indirect form reads it from memory.
// RULE16 - Instruction set of 63 instructions in 13 functional groups.
// RULE17 - Each instruction is one to four bytes: prefix, opcode, address bytes.
// RULE18 - Three prefix values before an opcode change its meaning.
// RULE19 - Prefix 90 swaps first index register for second.
// RULE20 - Prefix 92 turns direct, direct-bit, direct-relative into indirect form.
// RULE21 - Prefix 92 turns first-index indexed into indirect indexed, same register.
// RULE22 - Prefix 91 turns first-index indirect indexed into second-index form.
// RULE23 - Inherent instruction is one byte; opcode alone defines the operation.
// RULE24 - Offset is added to address of the following instruction: -128..+127.
// RULE25 - Short indexed sum keeps its ninth bit instead of wrapping.
`default_nettype none
package amd_pkg;
	localparam logic [7:0] SECOND_INDEX_PREFIX          = 8'h90;
	localparam logic [7:0] SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
	localparam logic [7:0] INDIRECT_PREFIX              = 8'h92;
	localparam int         NUM_INSTR                    = 63;
	localparam int         NUM_GROUPS                   = 13;
	localparam logic [2:0] LEN_MAX                      = 3'h4;
	localparam logic [15:0] SHORT_IDX_MAX               = 16'h01FE;
	localparam logic [15:0] ADDR_RST                    = 16'h0000;
	localparam logic [7:0]  OPC_RELATIVE_CALL           = 8'hAD;
	localparam logic [3:0] ROW_BTJ = 4'h0;
	localparam logic [3:0] ROW_BIT = 4'h1;
	localparam logic [3:0] ROW_REL = 4'h2;
	localparam logic [3:0] ROW_RMW_DIR = 4'h3;
	localparam logic [3:0] ROW_INH_A = 4'h4;
	localparam logic [3:0] ROW_INH_X = 4'h5;
	localparam logic [3:0] ROW_RMW_IDX_S = 4'h6;
	localparam logic [3:0] ROW_RMW_IDX0 = 4'h7;
	localparam logic [3:0] ROW_IMM = 4'hA;
	localparam logic [3:0] ROW_DIR_S = 4'hB;
	localparam logic [3:0] ROW_DIR_L = 4'hC;
	localparam logic [3:0] ROW_IDX_L = 4'hD;
	localparam logic [3:0] ROW_IDX_S = 4'hE;
	localparam logic [3:0] ROW_IDX0 = 4'hF;

	typedef enum logic [1:0] {
		PFX_NONE = 2'h0, PFX_Y = 2'h1, PFX_IND = 2'h2, PFX_IND_Y = 2'h3
	} amd_pfx_t;

	typedef enum logic [4:0] {
		AM_INH = 5'h00, AM_IMM = 5'h01, AM_DIR_S = 5'h02, AM_DIR_L = 5'h03,
		AM_IDX0 = 5'h04, AM_IDX_S = 5'h05, AM_IDX_L = 5'h06,
		AM_IND_S = 5'h07, AM_IND_L = 5'h08, AM_IIX_S = 5'h09,
		AM_IIX_L = 5'h0A, AM_REL = 5'h0B, AM_REL_IND = 5'h0C,
		AM_BIT = 5'h0D, AM_BIT_IND = 5'h0E, AM_BTJ = 5'h0F,
		AM_BTJ_IND = 5'h10, AM_BAD = 5'h1F
	} amd_mode_t;

	typedef enum logic [3:0] {
		GRP_LOAD = 4'h0, GRP_STACK = 4'h1, GRP_INCDEC = 4'h2,
		GRP_CMP = 4'h3, GRP_LOGIC = 4'h4, GRP_BIT = 4'h5, GRP_BTJ = 4'h6,
		GRP_ARITH = 4'h7, GRP_SHIFT = 4'h8, GRP_JUMP = 4'h9,
		GRP_BRANCH = 4'hA, GRP_INTR = 4'hB, GRP_FLAG = 4'hC, GRP_NONE = 4'hF
	} amd_grp_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_OP = 3'b001, ST_OPND = 3'b010,
		ST_PTR = 3'b011, ST_DONE = 3'b100
	} amd_state_t;

	typedef struct packed {
		amd_mode_t  mode;
		amd_grp_t   grp;
		logic       use_y;
		logic [1:0] n_opnd;
		logic [1:0] ptr_len;
	} amd_cls_t;

	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} amd_mem_req_t;

	typedef struct packed {
		amd_mode_t   mode;
		amd_grp_t    grp;
		logic [7:0]  opcode;
		amd_pfx_t    pfx;
		logic        use_y;
		logic [2:0]  len;
		logic [7:0]  operand;
		logic [15:0] ea;
		logic [15:0] next_pc;
		logic [15:0] target;
		logic        illegal;
	} amd_dec_t;
endpackage : amd_pkg
`default_nettype wire

// ==== amd_adder.sv ====
// address adder with zero or sign extension of the narrow operand
`timescale 1ns/100ps
`default_nettype none
module amd_adder #(
	parameter int W  = 16,
	parameter int OW = 8
) (
	input  wire logic [W-1:0]  base_i,
	input  wire logic [OW-1:0] off_i,
	input  wire logic          sx_i,
	output logic      [W-1:0]  sum_o
);
	logic [W-1:0] ext;

	assign ext   = sx_i ? {{(W-OW){off_i[OW-1]}}, off_i}
	                    : {{(W-OW){1'b0}}, off_i};
	assign sum_o = base_i + ext;
endmodule : amd_adder
`default_nettype wire

// ==== amd_classify.sv ====
// opcode and prefix classifier: mode, group, operand and pointer sizes
`timescale 1ns/100ps
`default_nettype none
module amd_classify (
	input  wire amd_pkg::amd_pfx_t pfx_i,
	input  wire logic [7:0]        opc_i,
	output var  amd_pkg::amd_cls_t cls_o
);
	logic [3:0]         row;
	logic [3:0]         col;
	amd_pkg::amd_grp_t  grp;
	amd_pkg::amd_mode_t base;
	amd_pkg::amd_mode_t mode;
	logic [1:0]         nb;
	logic [1:0]         pl;
	logic               bad;
	logic               y_ok;
	logic               long_ok;
	logic               is_long;

	assign row = opc_i[7:4];
	assign col = opc_i[3:0];

	// ****************************************
	// functional group of each opcode
	// ****************************************
	function automatic amd_pkg::amd_grp_t grp_of(input logic [7:0] opc);
		logic [3:0] r;
		logic [3:0] c;
		r = opc[7:4];
		c = opc[3:0];
		grp_of = amd_pkg::GRP_NONE;
		if (opc == amd_pkg::OPC_RELATIVE_CALL) begin
			grp_of = amd_pkg::GRP_JUMP;
		end else begin
			case (r)
			4'h0: grp_of = amd_pkg::GRP_BTJ;
			4'h1: grp_of = amd_pkg::GRP_BIT;
			4'h2: grp_of = amd_pkg::GRP_BRANCH;
			4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
				case (c)
				4'h0, 4'h3: grp_of = amd_pkg::GRP_LOGIC;
				4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE: grp_of = amd_pkg::GRP_SHIFT;
				4'hA, 4'hC: grp_of = amd_pkg::GRP_INCDEC;
				4'hD: grp_of = amd_pkg::GRP_CMP;
				4'hF: grp_of = amd_pkg::GRP_LOAD;
				4'h2: grp_of = (r == amd_pkg::ROW_INH_A) ? amd_pkg::GRP_ARITH
				                                         : amd_pkg::GRP_NONE;
				default: grp_of = amd_pkg::GRP_NONE;
				endcase
			end
			4'h8: begin
				case (c)
				4'h0, 4'h3, 4'hE, 4'hF: grp_of = amd_pkg::GRP_INTR;
				4'h1: grp_of = amd_pkg::GRP_JUMP;
				4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA: grp_of = amd_pkg::GRP_STACK;
				default: grp_of = amd_pkg::GRP_NONE;
				endcase
			end
			4'h9: begin
				case (c)
				4'h3, 4'h4, 4'h7, 4'hE, 4'hF: grp_of = amd_pkg::GRP_LOAD;
				4'h8, 4'h9, 4'hA, 4'hB: grp_of = amd_pkg::GRP_FLAG;
				4'hC: grp_of = amd_pkg::GRP_STACK;
				4'hD: grp_of = amd_pkg::GRP_JUMP;
				default: grp_of = amd_pkg::GRP_NONE;
				endcase
			end
			default: begin
				case (c)
				4'h0, 4'h2, 4'h9, 4'hB: grp_of = amd_pkg::GRP_ARITH;
				4'h1, 4'h3, 4'h5: grp_of = amd_pkg::GRP_CMP;
				4'h4, 4'h8, 4'hA: grp_of = amd_pkg::GRP_LOGIC;
				4'hC, 4'hD: grp_of = amd_pkg::GRP_JUMP;
				default: grp_of = amd_pkg::GRP_LOAD;
				endcase
			end
			endcase
		end
	endfunction : grp_of

	assign grp     = grp_of(opc_i); // RULE16
	assign y_ok    = (row == amd_pkg::ROW_INH_X) || (row >= amd_pkg::ROW_IMM)
	              || (row == amd_pkg::ROW_RMW_IDX_S)
	              || (row == amd_pkg::ROW_RMW_IDX0); // RULE19
	assign long_ok = grp inside {amd_pkg::GRP_LOAD, amd_pkg::GRP_CMP,
	                             amd_pkg::GRP_LOGIC, amd_pkg::GRP_ARITH}; // RULE12

	always_comb begin
		base = amd_pkg::AM_INH;
		nb   = 2'h0;
		if (opc_i == amd_pkg::OPC_RELATIVE_CALL) begin
			base = amd_pkg::AM_REL;
			nb   = 2'h1;
		end else begin
			case (row)
			amd_pkg::ROW_BTJ: begin base = amd_pkg::AM_BTJ; nb = 2'h2; end
			amd_pkg::ROW_BIT: begin base = amd_pkg::AM_BIT; nb = 2'h1; end
			amd_pkg::ROW_REL: begin base = amd_pkg::AM_REL; nb = 2'h1; end // RULE15
			amd_pkg::ROW_RMW_DIR, amd_pkg::ROW_DIR_S: begin
				base = amd_pkg::AM_DIR_S; nb = 2'h1; // RULE2
			end
			amd_pkg::ROW_RMW_IDX_S, amd_pkg::ROW_IDX_S: begin
				base = amd_pkg::AM_IDX_S; nb = 2'h1; // RULE6
			end
			amd_pkg::ROW_RMW_IDX0, amd_pkg::ROW_IDX0: base = amd_pkg::AM_IDX0; // RULE5
			amd_pkg::ROW_IMM: begin base = amd_pkg::AM_IMM; nb = 2'h1; end // RULE1
			amd_pkg::ROW_DIR_L: begin base = amd_pkg::AM_DIR_L; nb = 2'h2; end // RULE3
			amd_pkg::ROW_IDX_L: begin base = amd_pkg::AM_IDX_L; nb = 2'h2; end // RULE7
			default: base = amd_pkg::AM_INH; // RULE23
			endcase
		end
		mode  = base;
		pl    = 2'h0;
		bad   = (grp == amd_pkg::GRP_NONE);
		cls_o.use_y = 1'b0;
		case (pfx_i)
		amd_pkg::PFX_Y: begin
			cls_o.use_y = 1'b1; // RULE19
			bad = bad || !y_ok;
		end
		amd_pkg::PFX_IND: begin
			pl = 2'h1;
			case (base) // RULE20 RULE21
			amd_pkg::AM_BTJ:   mode = amd_pkg::AM_BTJ_IND;
			amd_pkg::AM_BIT:   mode = amd_pkg::AM_BIT_IND;
			amd_pkg::AM_REL:   mode = amd_pkg::AM_REL_IND;
			amd_pkg::AM_DIR_S: mode = amd_pkg::AM_IND_S;
			amd_pkg::AM_IDX_S: mode = amd_pkg::AM_IIX_S;
			amd_pkg::AM_DIR_L: begin mode = amd_pkg::AM_IND_L; pl = 2'h2; end
			amd_pkg::AM_IDX_L: begin mode = amd_pkg::AM_IIX_L; pl = 2'h2; end
			default: bad = 1'b1;
			endcase
		end
		amd_pkg::PFX_IND_Y: begin
			cls_o.use_y = 1'b1; // RULE22
			pl = 2'h1;
			case (base)
			amd_pkg::AM_IDX_S: mode = amd_pkg::AM_IIX_S;
			amd_pkg::AM_IDX_L: begin mode = amd_pkg::AM_IIX_L; pl = 2'h2; end
			default: bad = 1'b1;
			endcase
		end
		default: ;
		endcase
		// pointer location is always a single byte after the opcode
		if (pl == 2'h2) nb = 2'h1; // RULE9 RULE11
		is_long = mode inside {amd_pkg::AM_DIR_L, amd_pkg::AM_IDX_L,
		                       amd_pkg::AM_IND_L, amd_pkg::AM_IIX_L};
		if (is_long && !long_ok) bad = 1'b1; // RULE13
		if (mode == amd_pkg::AM_IMM && col inside {4'h7, 4'hC, 4'hF}) bad = 1'b1;
		cls_o.mode    = bad ? amd_pkg::AM_BAD : mode;
		cls_o.grp     = grp;
		cls_o.n_opnd  = bad ? 2'h0 : nb;
		cls_o.ptr_len = bad ? 2'h0 : pl;
	end
endmodule : amd_classify
`default_nettype wire

// ==== amd_decoder.sv ====
// addressing-mode decoder: fetches an instruction, resolves its address
`timescale 1ns/100ps
`default_nettype none
module amd_decoder (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	input  wire logic                  start_i,
	input  wire logic [15:0]           pc_i,
	input  wire logic [7:0]            idx_x_i,
	input  wire logic [7:0]            idx_y_i,
	output var  amd_pkg::amd_mem_req_t mem_o,
	input  wire logic [7:0]            mem_rdata_i,
	input  wire logic                  mem_ack_i,
	output logic                       busy_o,
	output logic                       done_o,
	output var  amd_pkg::amd_dec_t     dec_o
);
	amd_pkg::amd_state_t st;
	amd_pkg::amd_state_t next_st;
	amd_pkg::amd_pfx_t   pfx;
	amd_pkg::amd_pfx_t   pfx_in;
	amd_pkg::amd_cls_t   cls_w;
	amd_pkg::amd_cls_t   cls_q;
	amd_pkg::amd_mode_t  mode;
	amd_pkg::amd_state_t op_next;
	logic [7:0]          opcode;
	logic [7:0]          opc_in;
	logic [15:0]         fetch_addr;
	logic [15:0]         pc0;
	logic [2:0]          len;
	logic [15:0]         opnd;
	logic [15:0]         ptr;
	logic [1:0]          cnt;
	logic [1:0]          pcnt;
	logic                take;
	logic                is_pfx;
	logic                ptr_last;
	logic [7:0]          ptr_loc;
	logic [15:0]         ptr_addr;
	logic [7:0]          idx_val;
	logic [15:0]         idx_base;
	logic [15:0]         idx_sum;
	logic [15:0]         ea_w;
	logic [7:0]          rel_off;
	logic [15:0]         next_pc_w;
	logic [15:0]         target_w;
	logic                is_branch;
	logic                done;
	amd_pkg::amd_dec_t   dec;

	// ****************************************
	// fetch handshake and prefix detection
	// ****************************************
	assign busy_o     = (st != amd_pkg::ST_IDLE);
	assign mem_o.rd   = st inside {amd_pkg::ST_OP, amd_pkg::ST_OPND,
	                               amd_pkg::ST_PTR};
	assign mem_o.addr = (st == amd_pkg::ST_PTR) ? ptr_addr : fetch_addr;
	assign take       = mem_o.rd && mem_ack_i;
	// a second prefix is taken as an opcode and decodes as illegal
	assign is_pfx     = (pfx == amd_pkg::PFX_NONE)
	                 && (mem_rdata_i inside {amd_pkg::SECOND_INDEX_PREFIX,
	                     amd_pkg::INDIRECT_PREFIX,
	                     amd_pkg::SECOND_INDEX_INDIRECT_PREFIX}); // RULE18
	assign pfx_in     =
		(mem_rdata_i == amd_pkg::SECOND_INDEX_PREFIX) ? amd_pkg::PFX_Y :
		(mem_rdata_i == amd_pkg::INDIRECT_PREFIX)     ? amd_pkg::PFX_IND :
		                                                amd_pkg::PFX_IND_Y;
	assign opc_in     = (st == amd_pkg::ST_OP) ? mem_rdata_i : opcode;
	assign op_next    = (cls_w.mode == amd_pkg::AM_BAD
	                  || cls_w.n_opnd == 2'h0) ? amd_pkg::ST_DONE
	                                           : amd_pkg::ST_OPND;
	assign mode       = cls_q.mode;

	amd_classify u_classify (
		.pfx_i (pfx),
		.opc_i (opc_in),
		.cls_o (cls_w)
	);

	// ****************************************
	// pointer fetch in page zero
	// ****************************************
	// bit test-and-branch carries the location first, the offset second
	assign ptr_loc  = (mode == amd_pkg::AM_BTJ_IND) ? opnd[15:8] : opnd[7:0];
	// a word pointer at FF wraps to 00 rather than leaving page zero
	assign ptr_addr = {8'h00, ptr_loc + {7'h00, pcnt[0]}}; // RULE8 RULE9
	assign ptr_last = ((pcnt + 2'h1) == cls_q.ptr_len);

	// ****************************************
	// effective address and branch target
	// ****************************************
	assign idx_val  = cls_q.use_y ? idx_y_i : idx_x_i; // RULE19 RULE22
	assign idx_base =
		(mode == amd_pkg::AM_IIX_S) ? {8'h00, ptr[7:0]} : // RULE11
		(mode == amd_pkg::AM_IIX_L) ? ptr :               // RULE10
		(mode == amd_pkg::AM_IDX_S) ? {8'h00, opnd[7:0]} :
		(mode == amd_pkg::AM_IDX_L) ? opnd : amd_pkg::ADDR_RST;

	// 16-bit sum of a zero-extended byte keeps bit 8 for the short forms
	amd_adder #(.W(16), .OW(8)) u_ea_add (
		.base_i (idx_base),
		.off_i  (idx_val),
		.sx_i   (1'b0),
		.sum_o  (idx_sum)
	); // RULE4 RULE25

	amd_adder #(.W(16), .OW(8)) u_pc_add (
		.base_i (pc0),
		.off_i  ({5'h00, len}),
		.sx_i   (1'b0),
		.sum_o  (next_pc_w)
	); // RULE24

	assign rel_off   = (mode == amd_pkg::AM_REL_IND) ? ptr[7:0]
	                                                 : opnd[7:0]; // RULE15
	assign is_branch = mode inside {amd_pkg::AM_REL, amd_pkg::AM_REL_IND,
	                                amd_pkg::AM_BTJ, amd_pkg::AM_BTJ_IND};

	amd_adder #(.W(16), .OW(8)) u_rel_add (
		.base_i (next_pc_w),
		.off_i  (is_branch ? rel_off : 8'h00),
		.sx_i   (1'b1),
		.sum_o  (target_w)
	); // RULE14

	always_comb begin
		case (mode)
		amd_pkg::AM_DIR_S, amd_pkg::AM_BIT: ea_w = {8'h00, opnd[7:0]}; // RULE2
		amd_pkg::AM_DIR_L: ea_w = opnd; // RULE3
		amd_pkg::AM_BTJ:   ea_w = {8'h00, opnd[15:8]};
		amd_pkg::AM_IDX0, amd_pkg::AM_IDX_S, amd_pkg::AM_IDX_L,
		amd_pkg::AM_IIX_S, amd_pkg::AM_IIX_L: ea_w = idx_sum; // RULE5 RULE7
		amd_pkg::AM_IND_S, amd_pkg::AM_BIT_IND,
		amd_pkg::AM_BTJ_IND: ea_w = {8'h00, ptr[7:0]}; // RULE8
		amd_pkg::AM_IND_L: ea_w = ptr; // RULE9
		default: ea_w = amd_pkg::ADDR_RST;
		endcase
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		next_st = st;
		case (st)
		amd_pkg::ST_IDLE: if (start_i) next_st = amd_pkg::ST_OP;
		amd_pkg::ST_OP: if (take && !is_pfx) next_st = op_next; // RULE23
		amd_pkg::ST_OPND: if (take && cnt == 2'h1) begin
			next_st = (cls_q.ptr_len != 2'h0) ? amd_pkg::ST_PTR
			                                  : amd_pkg::ST_DONE;
		end
		amd_pkg::ST_PTR: if (take && ptr_last) next_st = amd_pkg::ST_DONE;
		amd_pkg::ST_DONE: next_st = amd_pkg::ST_IDLE;
		default: next_st = amd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) st <= amd_pkg::ST_IDLE;
		else st <= next_st;
	end

	// instruction stream bytes: prefix, opcode, operands
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fetch_addr <= amd_pkg::ADDR_RST;
			pc0        <= amd_pkg::ADDR_RST;
			len        <= 3'h0;
		end else if (st == amd_pkg::ST_IDLE && start_i) begin
			fetch_addr <= pc_i;
			pc0        <= pc_i;
			len        <= 3'h0;
		end else if (take && st != amd_pkg::ST_PTR) begin
			fetch_addr <= fetch_addr + 16'h0001;
			len        <= len + 3'h1; // RULE17
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || (st == amd_pkg::ST_IDLE && start_i)) begin
			pfx    <= amd_pkg::PFX_NONE;
			opcode <= 8'h00;
			cls_q  <= '0;
		end else if (take && st == amd_pkg::ST_OP) begin
			if (is_pfx) pfx <= pfx_in; // RULE18
			else begin
				opcode <= mem_rdata_i;
				cls_q  <= cls_w;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || (st == amd_pkg::ST_IDLE && start_i)) begin
			opnd <= 16'h0000;
			cnt  <= 2'h0;
		end else if (take && st == amd_pkg::ST_OP && !is_pfx) begin
			cnt <= cls_w.n_opnd;
		end else if (take && st == amd_pkg::ST_OPND) begin
			opnd <= {opnd[7:0], mem_rdata_i}; // RULE3 RULE7
			cnt  <= cnt - 2'h1;
		end
	end

	// pointer word arrives high byte first
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || (st == amd_pkg::ST_IDLE && start_i)) begin
			ptr  <= 16'h0000;
			pcnt <= 2'h0;
		end else if (take && st == amd_pkg::ST_PTR) begin
			ptr  <= {ptr[7:0], mem_rdata_i}; // RULE10
			pcnt <= pcnt + 2'h1;
		end
	end

	// ****************************************
	// result register
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			dec  <= '0;
			done <= 1'b0;
		end else begin
			done <= (st == amd_pkg::ST_DONE);
			if (st == amd_pkg::ST_DONE) begin
				dec.mode    <= mode;
				dec.grp     <= cls_q.grp;
				dec.opcode  <= opcode;
				dec.pfx     <= pfx;
				dec.use_y   <= cls_q.use_y;
				dec.len     <= len;
				dec.operand <= opnd[7:0]; // RULE1
				dec.ea      <= ea_w;
				dec.next_pc <= next_pc_w;
				dec.target  <= target_w;
				dec.illegal <= (mode == amd_pkg::AM_BAD);
			end
		end
	end

	assign done_o = done;
	assign dec_o  = dec;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_imm_len: assert property (done && dec.mode == amd_pkg::AM_IMM
		|-> dec.len == 3'h2 + {2'h0, dec.pfx != amd_pkg::PFX_NONE})
		else $error("immediate length wrong"); // RULE1
	a_short_dir_page: assert property (done && dec.mode == amd_pkg::AM_DIR_S
		|-> dec.ea[15:8] == 8'h00) else $error("short direct left page zero"); // RULE2
	a_long_dir_len: assert property (done && dec.mode == amd_pkg::AM_DIR_L
		|-> dec.len == 3'h3 + {2'h0, dec.pfx != amd_pkg::PFX_NONE})
		else $error("long direct length wrong"); // RULE3
	a_idx0_len: assert property (done && dec.mode == amd_pkg::AM_IDX0
		|-> dec.len == 3'h1 + {2'h0, dec.pfx != amd_pkg::PFX_NONE}
		&& dec.ea[15:8] == 8'h00) else $error("no-offset index wrong"); // RULE5
	a_short_idx_max: assert property (done && (dec.mode == amd_pkg::AM_IDX_S
		|| dec.mode == amd_pkg::AM_IIX_S) |-> dec.ea <= amd_pkg::SHORT_IDX_MAX)
		else $error("short indexed out of range"); // RULE6
	a_ind_long_len: assert property (done && (dec.mode == amd_pkg::AM_IND_L
		|| dec.mode == amd_pkg::AM_IIX_L) |-> dec.len == 3'h3)
		else $error("long indirect length wrong"); // RULE9
	a_long_ops_only: assert property (done && dec.mode inside {
		amd_pkg::AM_DIR_L, amd_pkg::AM_IDX_L, amd_pkg::AM_IND_L,
		amd_pkg::AM_IIX_L} |-> dec.grp inside {amd_pkg::GRP_LOAD,
		amd_pkg::GRP_CMP, amd_pkg::GRP_LOGIC, amd_pkg::GRP_ARITH})
		else $error("long form on short-only op"); // RULE13
	a_rel_reach: assert property (done && dec.mode == amd_pkg::AM_REL
		|-> (dec.target - dec.next_pc) + 16'h0080 <= 16'h00FF)
		else $error("relative target out of reach"); // RULE24
	a_len_range: assert property (done |-> dec.len >= 3'h1
		&& dec.len <= amd_pkg::LEN_MAX) else $error("length out of range"); // RULE17
	a_inh_len: assert property (done && dec.mode == amd_pkg::AM_INH
		&& dec.pfx == amd_pkg::PFX_NONE |-> dec.len == 3'h1)
		else $error("inherent length wrong"); // RULE23
	a_pfx_y: assert property (done && dec.pfx == amd_pkg::PFX_IND_Y
		&& !dec.illegal |-> dec.use_y && dec.mode inside {
		amd_pkg::AM_IIX_S, amd_pkg::AM_IIX_L})
		else $error("second-index indirect prefix misdecoded"); // RULE22
	a_done_pulse: assert property (done |-> !busy_o ##1 !done)
		else $error("done not a single pulse");

	c_imm: cover property (done && dec.mode == amd_pkg::AM_IMM);
	c_iix_y: cover property (done && dec.mode == amd_pkg::AM_IIX_S
		&& dec.use_y);
	c_rel_ind: cover property (done && dec.mode == amd_pkg::AM_REL_IND);
	c_btj_ind: cover property (done && dec.mode == amd_pkg::AM_BTJ_IND);
endmodule : amd_decoder
`default_nettype wire

// ==== amd_mem_model.sv ====
// partner model: byte-wide program and data memory on the cpu bus
`timescale 1ns/100ps
`default_nettype none
module amd_mem_model (
	input  wire logic                  clk_sys_i,
	input  wire logic                  stall_i,
	input  wire amd_pkg::amd_mem_req_t mem_i,
	output logic      [7:0]            rdata_o,
	output logic                       ack_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	// unacked cycles show the complement so stale data never looks valid
	assign ack_o   = mem_i.rd & ~stall_i;
	assign rdata_o = ack_o ? mem[mem_i.addr] : ~last;
	always @(posedge clk_sys_i) begin
		if (ack_o)
			last <= rdata_o;
	end
endmodule : amd_mem_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic                  clk_sys_i = 1'b0;
	logic                  rst_i     = 1'b1;
	logic                  start_i   = 1'b0;
	logic [15:0]           pc_i      = 16'h0000;
	logic [7:0]            idx_x_i   = 8'h00;
	logic [7:0]            idx_y_i   = 8'h00;
	logic                  slow      = 1'b0;
	logic                  stall     = 1'b0;
	logic [1:0]            cyc       = 2'h0;
	logic [7:0]            o, p0;
	logic [31:0]           v;
	logic [31:0]           seed      = 32'h000046CD;
	amd_pkg::amd_mem_req_t mem_o;
	logic [7:0]            rdata;
	logic                  ack, busy_o, done_o;
	amd_pkg::amd_dec_t     dec_o, e;
	amd_pkg::amd_dec_t     exp_q[$];
	int                    kind_q[$];
	int                    k, p, r;
	int                    fails       = 0;
	int                    comparisons = 0;

	amd_decoder i_amd_decoder (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.start_i(start_i), .pc_i(pc_i), .idx_x_i(idx_x_i), .idx_y_i(idx_y_i),
		.mem_o(mem_o), .mem_rdata_i(rdata), .mem_ack_i(ack), .busy_o(busy_o),
		.done_o(done_o), .dec_o(dec_o));
	amd_mem_model i_amd_mem_model (.clk_sys_i(clk_sys_i), .stall_i(stall),
		.mem_i(mem_o), .rdata_o(rdata), .ack_o(ack));

	initial forever #10 clk_sys_i = ~clk_sys_i;
	// slow passes withhold ack three cycles in four
	always @(posedge clk_sys_i) begin
		#1;
		cyc = cyc + 2'h1;
		stall = slow & (cyc != 2'h0);
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic finish_test();
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// kind: 0 none, 1 address, 2 operand, 3 target (ea=offset), 4 address+target
	task automatic go(input logic [31:0] b, input int n,
		input amd_pkg::amd_mode_t m, input logic [15:0] ea, input logic uy,
		input int kd);
		amd_pkg::amd_dec_t x;
		int i;
		x = '0;
		pc_i = 16'h8000 | 16'(rnd() & 32'h0FFF);
		for (i = 0; i < n; i++)
			i_amd_mem_model.mem[pc_i + 16'(i)] = b[31 - 8 * i -: 8];
		x.mode = m;
		x.len = 3'(n);
		x.ea = ea;
		x.use_y = uy;
		x.illegal = (m == amd_pkg::AM_BAD);
		x.operand = b[31 - 8 * (n - 1) -: 8];
		x.next_pc = pc_i + 16'(n);
		x.target = x.next_pc + ((kd == 3) ? {{8{ea[7]}}, ea[7:0]}
			: (kd == 4) ? {{8{x.operand[7]}}, x.operand} : 16'h0000);
		x.pfx = (b[31:24] == amd_pkg::SECOND_INDEX_PREFIX) ? amd_pkg::PFX_Y
			: (b[31:24] == amd_pkg::INDIRECT_PREFIX) ? amd_pkg::PFX_IND
			: (b[31:24] == amd_pkg::SECOND_INDEX_INDIRECT_PREFIX)
			? amd_pkg::PFX_IND_Y : amd_pkg::PFX_NONE;
		x.opcode = (x.pfx == amd_pkg::PFX_NONE) ? b[31:24] : b[23:16];
		x.grp = (x.opcode[3:0] == 4'h6) ? amd_pkg::GRP_LOAD
			: (x.opcode[7:4] == 4'h0) ? amd_pkg::GRP_BTJ
			: (x.opcode[7:4] == 4'h1) ? amd_pkg::GRP_BIT
			: (x.opcode[7:4] == 4'h2) ? amd_pkg::GRP_BRANCH
			: (x.opcode == 8'h3C) ? amd_pkg::GRP_INCDEC
			: (x.opcode == 8'h90) ? amd_pkg::GRP_NONE : amd_pkg::GRP_JUMP;
		exp_q.push_back(x);
		kind_q.push_back(kd);
		start_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		start_i = 1'b0;
		for (i = 0; i < 300 && done_o !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk("done", 16'(done_o === 1'b1), 16'h0001);
	endtask : go

	always @(negedge clk_sys_i) begin
		if (done_o === 1'b1) begin
			chk("queue", 16'(exp_q.size() == 0), 16'h0000);
			e = exp_q.pop_front();
			k = kind_q.pop_front();
			chk("mode", 16'(dec_o.mode), 16'(e.mode));
			chk("illegal", 16'(dec_o.illegal), 16'(e.illegal));
			chk("opcode", 16'(dec_o.opcode), 16'(e.opcode));
			chk("pfx", 16'(dec_o.pfx), 16'(e.pfx));
			chk("grp", 16'(dec_o.grp), 16'(e.grp));
			chk("busy", 16'(busy_o), 16'h0000);
			if (!e.illegal) begin
				chk("len", 16'(dec_o.len), 16'(e.len));
				chk("next_pc", dec_o.next_pc, e.next_pc);
				chk("target", dec_o.target, e.target);
				chk("use_y", 16'(dec_o.use_y), 16'(e.use_y));
			end
			if (k == 1 || k == 4)
				chk("ea", dec_o.ea, e.ea);
			if (k == 2)
				chk("operand", 16'(dec_o.operand), 16'(e.operand));
		end
	end

	initial begin
		#200000;
		fails++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		for (p = 0; p < 2; p++) begin
			slow = (p == 1);
			for (r = 0; r < 4; r++) begin
				v = rnd();
				{p0, o, idx_y_i, idx_x_i} = v;
				i_amd_mem_model.mem[16'h0010] = p0;
				i_amd_mem_model.mem[16'h0011] = o;
				go(32'h9D000000, 1, amd_pkg::AM_INH, 0, 0, 0);
				go({8'hA6, o, 16'h0}, 2, amd_pkg::AM_IMM, 0, 0, 2);
				go({8'hB6, o, 16'h0}, 2, amd_pkg::AM_DIR_S, 16'(o), 0, 1);
				go({8'hC6, p0, o, 8'h0}, 3, amd_pkg::AM_DIR_L, {p0, o}, 0, 1);
				go(32'hF6000000, 1, amd_pkg::AM_IDX0, 16'(idx_x_i), 0, 1);
				go({8'hE6, o, 16'h0}, 2, amd_pkg::AM_IDX_S,
					16'(o) + 16'(idx_x_i), 0, 1);
				go({8'hD6, p0, o, 8'h0}, 3, amd_pkg::AM_IDX_L,
					{p0, o} + 16'(idx_x_i), 0, 1);
				go(32'h90F60000, 2, amd_pkg::AM_IDX0, 16'(idx_y_i), 1, 1);
				go(32'h92B61000, 3, amd_pkg::AM_IND_S, 16'(p0), 0, 1);
				go(32'h92C61000, 3, amd_pkg::AM_IND_L, {p0, o}, 0, 1);
				go(32'h92E61000, 3, amd_pkg::AM_IIX_S,
					16'(p0) + 16'(idx_x_i), 0, 1);
				go(32'h91E61000, 3, amd_pkg::AM_IIX_S,
					16'(p0) + 16'(idx_y_i), 1, 1);
				go(32'h92D61000, 3, amd_pkg::AM_IIX_L,
					{p0, o} + 16'(idx_x_i), 0, 1);
				go({8'h27, o, 16'h0}, 2, amd_pkg::AM_REL, 16'(o), 0, 3);
				go({amd_pkg::OPC_RELATIVE_CALL, o, 16'h0}, 2, amd_pkg::AM_REL,
					16'(o), 0, 3);
				go(32'h92271000, 3, amd_pkg::AM_REL_IND, 16'(p0), 0, 3);
				go({8'h3C, o, 16'h0}, 2, amd_pkg::AM_DIR_S, 16'(o), 0, 1);
				go({8'h10, o, 16'h0}, 2, amd_pkg::AM_BIT, 16'(o), 0, 1);
				go({8'h01, o, p0, 8'h0}, 3, amd_pkg::AM_BTJ, 16'(o), 0, 4);
				go({24'h920010, o}, 4, amd_pkg::AM_BTJ_IND,
					16'(p0), 0, 4);
				go(32'hCC123400, 3, amd_pkg::AM_BAD, 0, 0, 0);
				go(32'h90900000, 2, amd_pkg::AM_BAD, 0, 0, 0);
			end
		end
		repeat (3) @(posedge clk_sys_i);
		chk("drain", 16'(exp_q.size()), 16'h0000);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
